// File: hdl/mef_regs.svh
/*
 * Register indices, field positions, reset values and timing constants
 * of the metering error and status flag bank.
 * Assumes a 50 MHz core clock; byte address is four times the index.
 */
// Behaviour
// R1: Each half-cycle sag flag sets while its quantity sags; resets zero, write one clears.
// R2: Sag flags sit in status bits 0..3: A voltage, A current, B voltage, B current.
// R3: Internal faults flag error bits 1..5, 7, 21, 22; host then resets everything.
// R4: Each converter status register with any bit set raises its summary bit.
// R5: Summary bits pack three per converter from bit 9 up to bit 20.
// R6: Bit 8 sets when converter data-ready does not arrive at 4 kHz; the checker only arms at the first data-ready edge after reset.
// R7: While bit 8 is set, samples are not processed, outputs stay unchanged.
// R8: Bit 6 sets on any converter CRC failure; write one clears it.
// R9: Bit 0 sets when converter initialisation fails; resets zero, write one clears.
// R10: Mask zero bit 31, reset zero, enables interrupt on aux five crossing.
// R11: Error bits 31 down to 23 read zero and ignore writes.
// R12: Interrupt is high while any flag and its mask bit are both set.
`ifndef MEF_REGS_SVH
`define MEF_REGS_SVH

`define MEF_IDX_SAG_FLAGS   12'h403
`define MEF_IDX_ERROR_FLAGS 12'h404
`define MEF_IDX_MASK_ZERO   12'h405
`define MEF_IDX_SAG_MASK    12'h406
`define MEF_IDX_ERROR_MASK  12'h407
`define MEF_IDX_CROSS_FLAGS 12'h408

`define MEF_SAG_W           4
`define MEF_BIT_INIT_ERR    0
`define MEF_BIT_CRC_ERR     6
`define MEF_BIT_RATE_ERR    8
`define MEF_BIT_CONV_BASE   9
`define MEF_BIT_AUX_FIVE_CROSS 31
`define MEF_ERR_VALID_MASK  32'h007f_ffff
`define MEF_FAULT_BITS      32'h0060_00be
`define MEF_RESET_VALUE     32'h0000_0000

`define MEF_CLK_PERIOD_NS   20
`define MEF_DRDY_PERIOD_NS  250000
`define MEF_DRDY_TOL_NS     2500
`define MEF_DRDY_MIN_CYC \
	((`MEF_DRDY_PERIOD_NS - `MEF_DRDY_TOL_NS + `MEF_CLK_PERIOD_NS - 1) \
	/ `MEF_CLK_PERIOD_NS)
`define MEF_DRDY_MAX_CYC \
	((`MEF_DRDY_PERIOD_NS + `MEF_DRDY_TOL_NS) / `MEF_CLK_PERIOD_NS)

`endif

// File: hdl/mef_pkg.sv
/*
 * Types of the metering error and status flag bank.
 * Assumes nothing beyond the constants header.
 */
package mef_pkg;

	// Captured AHB-Lite address phase
	typedef struct packed {
		logic        valid;
		logic        write;
		logic [11:0] idx;
	} mef_req_t;

	// Data-ready rate checker states
	typedef enum logic [1:0] {
		MEF_WAIT_FIRST = 2'b01,
		MEF_RUN        = 2'b10
	} mef_rate_t;

endpackage : mef_pkg

// File: hdl/mef_error_status.sv
/*
 * Error, sag and crossing flag bank of the metering core, with an
 * AHB-Lite slave, interrupt masks and data-ready rate supervision.
 * Assumes event inputs are clk_sys pulses; convDataReady is a pin.
 */
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/1ps
`include "mef_regs.svh"

module mef_error_status
	import mef_pkg::*;
#(
	parameter int STAT_W  = 8,
	parameter int MIN_CYC = `MEF_DRDY_MIN_CYC,
	parameter int MAX_CYC = `MEF_DRDY_MAX_CYC,
	parameter int CNT_W   = 16
) (
	// Clock and reset
	input  wire logic                  clk_sys,
	input  wire logic                  rst_n,
	// AHB-Lite slave
	input  wire logic                  hsel,
	input  wire logic [31:0]           haddr,
	input  wire logic [1:0]            htrans,
	input  wire logic                  hwrite,
	input  wire logic [2:0]            hsize,
	input  wire logic [31:0]           hwdata,
	input  wire logic                  hready,
	output logic      [31:0]           hrdata,
	output logic                       hreadyout,
	output logic                       hresp,
	// Detector events
	input  wire logic [3:0]            sagLevel,
	input  wire logic [7:0]            internalFault,
	input  wire logic [12*STAT_W-1:0]  convStatus,
	input  wire logic                  convStatusValid,
	input  wire logic                  convCrcFail,
	input  wire logic                  convInitFail,
	input  wire logic                  auxFiveCrossing,
	input  wire logic                  convDataReady,
	// Results
	output logic                       sampleTake,
	output logic                       resetAdvice,
	output logic                       irq
);

	mef_req_t         req;
	logic [3:0]       sagFlags;
	logic [3:0]       sagMask;
	logic [31:0]      errFlags;
	logic [31:0]      errMask;
	logic             crossFlag;
	logic             maskZero;
	logic             wrEn;
	logic [1:0]       drdySync;
	logic             drdyLast;
	logic             drdyEdge;
	mef_rate_t        rateState;
	logic [CNT_W-1:0] rateCnt;
	logic             rateSet;
	logic [31:0]      errSet;
	logic [31:0]      sagClr;
	logic [31:0]      errClr;
	logic [31:0]      crossClr;
	logic             addrOk;
	logic [11:0]      rdIdx;

	// OR of one converter status register
	function automatic logic anyBit(input logic [STAT_W-1:0] v);
		return |v;
	endfunction : anyBit

	// Clear mask for a W1C write to one index
	function automatic logic [31:0] w1c(input logic [11:0] idx);
		return (wrEn && req.idx == idx) ? hwdata : 32'h0000_0000;
	endfunction : w1c

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign wrEn      = req.valid & req.write;

	// W1C clear masks, one per flag register
	always_comb begin
		sagClr   = w1c(`MEF_IDX_SAG_FLAGS);
		errClr   = w1c(`MEF_IDX_ERROR_FLAGS);
		crossClr = w1c(`MEF_IDX_CROSS_FLAGS);
	end

	// Only aligned word accesses inside the map
	assign addrOk = hsel & htrans[1] & (hsize == 3'h2)
		& (haddr[1:0] == 2'h0) & (haddr[31:14] == 18'h0);
	// Refused reads land on the unmapped default
	assign rdIdx  = addrOk ? haddr[13:2] : 12'hfff;

	// Address phase capture
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			req <= '0;
		end else if (hready) begin
			req.valid <= addrOk;
			req.write <= hwrite;
			req.idx   <= haddr[13:2];
		end
	end

	// Read data registered at address phase
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			hrdata <= 32'h0000_0000;
		end else if (hready && hsel && htrans[1] && !hwrite) begin
			case (rdIdx)
				`MEF_IDX_SAG_FLAGS:   hrdata <= {28'h0, sagFlags};
				// R11 reserved read zero
				`MEF_IDX_ERROR_FLAGS: hrdata <= errFlags & `MEF_ERR_VALID_MASK;
				`MEF_IDX_MASK_ZERO:   hrdata <= {maskZero, 31'h0};
				`MEF_IDX_SAG_MASK:    hrdata <= {28'h0, sagMask};
				`MEF_IDX_ERROR_MASK:  hrdata <= errMask & `MEF_ERR_VALID_MASK;
				`MEF_IDX_CROSS_FLAGS: hrdata <= {crossFlag, 31'h0};
				default:              hrdata <= 32'h0000_0000;
			endcase
		end
	end

	// R1 sticky sag flags, set wins
	// R2 bit order A-V, A-I, B-V, B-I
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sagFlags <= 4'h0;
		end else begin
			sagFlags <= (sagFlags & ~sagClr[3:0]) | sagLevel;
		end
	end

	// Collected error events
	always_comb begin
		errSet = 32'h0000_0000;
		// R9 initialisation failure
		errSet[`MEF_BIT_INIT_ERR] = convInitFail;
		// R3 internal faults
		errSet[5:1]   = internalFault[4:0];
		errSet[7]     = internalFault[5];
		errSet[22:21] = internalFault[7:6];
		// R8 converter CRC failure
		errSet[`MEF_BIT_CRC_ERR] = convCrcFail;
		// R6 data-ready rate
		errSet[`MEF_BIT_RATE_ERR] = rateSet;
		// R4 R5 per-register summaries
		for (int i = 0; i < 12; i++) begin
			errSet[`MEF_BIT_CONV_BASE + i] = convStatusValid
				& anyBit(convStatus[i*STAT_W +: STAT_W]);
		end
	end

	// R11 reserved bits never stored
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			errFlags <= `MEF_RESET_VALUE;
		end else begin
			errFlags <= ((errFlags & ~errClr) | errSet)
				& `MEF_ERR_VALID_MASK;
		end
	end

	// R3 host must reset device and converters
	assign resetAdvice = |(errFlags & `MEF_FAULT_BITS);

	// Crossing flag, set wins
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			crossFlag <= 1'b0;
		end else begin
			crossFlag <= (crossFlag & ~crossClr[`MEF_BIT_AUX_FIVE_CROSS])
				| auxFiveCrossing;
		end
	end

	// Mask registers
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			maskZero <= 1'b0;
			sagMask  <= 4'h0;
			errMask  <= `MEF_RESET_VALUE;
		end else if (wrEn) begin
			case (req.idx)
				// R10 aux five crossing enable
				`MEF_IDX_MASK_ZERO:  maskZero <= hwdata[`MEF_BIT_AUX_FIVE_CROSS];
				`MEF_IDX_SAG_MASK:   sagMask  <= hwdata[3:0];
				`MEF_IDX_ERROR_MASK: errMask  <= hwdata & `MEF_ERR_VALID_MASK;
				default:             maskZero <= maskZero;
			endcase
		end
	end

	// R12 level interrupt from masked flags
	assign irq = |(sagFlags & sagMask) | |(errFlags & errMask)
		| (crossFlag & maskZero);

	// Data-ready pin synchroniser
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			drdySync <= 2'h0;
			drdyLast <= 1'b0;
		end else begin
			drdySync <= {drdySync[0], convDataReady};
			drdyLast <= drdySync[1];
		end
	end

	assign drdyEdge = drdySync[1] & ~drdyLast;

	// R6 period check between data-ready edges
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rateState <= MEF_WAIT_FIRST;
			rateCnt   <= '0;
			rateSet   <= 1'b0;
		end else begin
			rateSet <= 1'b0;
			case (rateState)
				MEF_WAIT_FIRST: begin
					rateCnt <= '0;
					if (drdyEdge) begin
						rateState <= MEF_RUN;
					end
				end
				MEF_RUN: begin
					if (drdyEdge) begin
						rateCnt <= '0;
						rateSet <= (rateCnt < CNT_W'(MIN_CYC - 1));
					end else if (rateCnt >= CNT_W'(MAX_CYC - 1)) begin
						rateCnt <= '0;
						rateSet <= 1'b1;
					end else begin
						rateCnt <= rateCnt + 1'b1;
					end
				end
				default: begin
					rateState <= MEF_WAIT_FIRST;
					rateCnt   <= '0;
				end
			endcase
		end
	end

	// R7 hold sample processing while rate error stands
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sampleTake <= 1'b0;
		end else begin
			sampleTake <= drdyEdge & ~errFlags[`MEF_BIT_RATE_ERR] & ~rateSet;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	sequence s_sagClear;
		wrEn && req.idx == `MEF_IDX_SAG_FLAGS && hwdata[0] && !sagLevel[0];
	endsequence

	sequence s_rateOverrun;
		rateState == MEF_RUN && !drdyEdge && rateCnt >= CNT_W'(MAX_CYC - 1);
	endsequence

	property p_sagSet;
		sagLevel[0] |=> sagFlags[0];
	endproperty
	a_sagSet: assert property (p_sagSet) // R1
		else $error("sag flag did not set");

	property p_sagClear;
		s_sagClear |=> !sagFlags[0];
	endproperty
	a_sagClear: assert property (p_sagClear) // R1
		else $error("sag flag did not clear");

	property p_fault;
		internalFault[6] |=> errFlags[21] && resetAdvice;
	endproperty
	a_fault: assert property (p_fault) // R3
		else $error("internal fault not flagged");

	property p_convSum;
		convStatusValid && anyBit(convStatus[11*STAT_W +: STAT_W])
			|=> errFlags[20];
	endproperty
	a_convSum: assert property (p_convSum) // R5
		else $error("converter summary not set");

	property p_rate;
		s_rateOverrun |=> rateSet ##1 errFlags[`MEF_BIT_RATE_ERR];
	endproperty
	a_rate: assert property (p_rate) // R6
		else $error("missing data-ready not flagged");

	property p_stall;
		errFlags[`MEF_BIT_RATE_ERR] |=> !sampleTake;
	endproperty
	a_stall: assert property (p_stall) // R7
		else $error("sample taken during rate error");

	property p_crc;
		convCrcFail |=> errFlags[`MEF_BIT_CRC_ERR];
	endproperty
	a_crc: assert property (p_crc) // R8
		else $error("crc error not flagged");

	property p_init;
		convInitFail |=> errFlags[`MEF_BIT_INIT_ERR];
	endproperty
	a_init: assert property (p_init) // R9
		else $error("init error not flagged");

	property p_cross;
		auxFiveCrossing && maskZero
			&& !(wrEn && req.idx == `MEF_IDX_MASK_ZERO) |=> irq;
	endproperty
	a_cross: assert property (p_cross) // R10
		else $error("crossing interrupt missing");

	property p_maskWrite;
		wrEn && req.idx == `MEF_IDX_MASK_ZERO
			|=> maskZero == $past(hwdata[`MEF_BIT_AUX_FIVE_CROSS]);
	endproperty
	a_maskWrite: assert property (p_maskWrite) // R10
		else $error("mask zero write lost");

	property p_sagIrq;
		sagLevel[3] && sagMask[3]
			&& !(wrEn && req.idx == `MEF_IDX_SAG_MASK) |=> irq;
	endproperty
	a_sagIrq: assert property (p_sagIrq) // R12
		else $error("masked sag did not interrupt");

	property p_crcClear;
		wrEn && req.idx == `MEF_IDX_ERROR_FLAGS
			&& hwdata[`MEF_BIT_CRC_ERR] && !convCrcFail
			|=> !errFlags[`MEF_BIT_CRC_ERR];
	endproperty
	a_crcClear: assert property (p_crcClear) // R8
		else $error("crc error did not clear");

	property p_rsvd;
		errFlags[31:23] == 9'h000 && errMask[31:23] == 9'h000;
	endproperty
	a_rsvd: assert property (p_rsvd) // R11
		else $error("reserved error bit set");

	property p_irqFall;
		$fell(irq) |-> $past(wrEn);
	endproperty
	a_irqFall: assert property (p_irqFall) // R12
		else $error("interrupt fell without a write");

endmodule : mef_error_status

// File: tb/mef_error_status_tb.sv
/* Self-checking bench of the flag bank: bus, events, masks, rate check.
   Assumes hdl/ on the include path and one 50 MHz clock. */
`timescale 1ns/1ps
`include "mef_regs.svh"

module mef_error_status_tb import mef_pkg::*;;
	logic        clk_sys, rst_n, hsel, hwrite, hready;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [3:0]  sagLevel;
	logic [7:0]  internalFault;
	logic [95:0] convStatus;
	logic        convStatusValid, convCrcFail, convInitFail;
	logic        auxFiveCrossing, convDataReady;
	logic        hreadyout, hresp, sampleTake, resetAdvice, irq;
	int          badCount, numChecks;
	int          takes = 0;

	assign hready = hreadyout;

	mef_error_status #(.MIN_CYC(40), .MAX_CYC(60)) dut (
		.clk_sys, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready, .hrdata, .hreadyout, .hresp, .sagLevel,
		.internalFault, .convStatus, .convStatusValid, .convCrcFail,
		.convInitFail, .auxFiveCrossing, .convDataReady, .sampleTake,
		.resetAdvice, .irq);

	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys) if (sampleTake === 1'b1) takes++;

	task automatic wrapUp;
		$display("checks %0d mismatches %0d", numChecks, badCount);
		if (badCount == 0 && numChecks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : wrapUp

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		numChecks++;
		if (got !== exp) begin
			badCount++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk

	task automatic waitRdy;
		do begin
			@(posedge clk_sys);
		end while (hready !== 1'b1);
	endtask : waitRdy

	// One single word transfer, then one idle cycle
	task automatic bus(input logic wr, input logic [11:0] idx,
		input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= {18'h0, idx, 2'b00};
		htrans <= 2'b10;
		hwrite <= wr;
		hsize <= 3'b010;
		waitRdy();
		htrans <= 2'b00;
		hwdata <= wd;
		waitRdy();
		rd = hrdata;
		@(posedge clk_sys);
	endtask : bus

	task automatic rdchk(input logic [11:0] idx, input logic [31:0] exp);
		bus(1'b0, idx, 32'h0);
		chk(rd, exp);
	endtask : rdchk

	// Pulse one event: 0..7 fault, 8 crc, 9 init, 10 crossing
	task automatic ev(input int k);
		internalFault <= (k < 8) ? 8'h01 << k : 8'h00;
		convCrcFail <= (k == 8);
		convInitFail <= (k == 9);
		auxFiveCrossing <= (k == 10);
		@(posedge clk_sys);
		internalFault <= 8'h00;
		convCrcFail <= 1'b0;
		convInitFail <= 1'b0;
		auxFiveCrossing <= 1'b0;
		@(posedge clk_sys);
	endtask : ev

	task automatic tResets;
		rdchk(`MEF_IDX_ERROR_FLAGS, 32'h0);
		rdchk(`MEF_IDX_SAG_FLAGS, 32'h0);
		rdchk(`MEF_IDX_MASK_ZERO, 32'h0);
		chk({31'h0, irq}, 32'h0);
	endtask : tResets

	task automatic tSag;
		sagLevel <= 4'b0101;
		repeat (2) @(posedge clk_sys);
		sagLevel <= 4'b0000;
		@(posedge clk_sys);
		rdchk(`MEF_IDX_SAG_FLAGS, 32'h5);
		bus(1'b1, `MEF_IDX_SAG_FLAGS, 32'h1);
		rdchk(`MEF_IDX_SAG_FLAGS, 32'h4);
		sagLevel <= 4'b1010;
		@(posedge clk_sys);
		sagLevel <= 4'b0000;
		@(posedge clk_sys);
		rdchk(`MEF_IDX_SAG_FLAGS, 32'he);
		bus(1'b1, `MEF_IDX_SAG_FLAGS, 32'hf);
		rdchk(`MEF_IDX_SAG_FLAGS, 32'h0);
	endtask : tSag

	task automatic tFaults;
		int pos[10] = '{1, 2, 3, 4, 5, 7, 21, 22, 6, 0};
		for (int k = 0; k < 10; k++) begin
			ev(k);
			chk({31'h0, resetAdvice}, 32'(k < 8));
			rdchk(`MEF_IDX_ERROR_FLAGS, 32'h1 << pos[k]);
			bus(1'b1, `MEF_IDX_ERROR_FLAGS, 32'h1 << pos[k]);
			rdchk(`MEF_IDX_ERROR_FLAGS, 32'h0);
		end
		bus(1'b1, `MEF_IDX_ERROR_FLAGS, 32'hff80_0000);
		rdchk(`MEF_IDX_ERROR_FLAGS, 32'h0);
		bus(1'b1, 12'h400, 32'hffff_ffff);
		rdchk(12'h400, 32'h0);
		chk({31'h0, hresp}, 32'h0);
	endtask : tFaults

	task automatic tConv;
		for (int i = 0; i <= 12; i++) begin
			convStatus <= (i < 12) ? 96'h1 << (i * 8 + i % 8) : 96'h0;
			convStatusValid <= 1'b1;
			@(posedge clk_sys);
			convStatusValid <= 1'b0;
			@(posedge clk_sys);
			rdchk(`MEF_IDX_ERROR_FLAGS, (i < 12) ? 32'h1 << (9 + i) : 0);
			bus(1'b1, `MEF_IDX_ERROR_FLAGS, 32'hffff_ffff);
		end
		convStatus <= {12{8'hff}};
		repeat (2) @(posedge clk_sys);
		rdchk(`MEF_IDX_ERROR_FLAGS, 32'h0);
	endtask : tConv

	task automatic tIrq;
		bus(1'b1, `MEF_IDX_MASK_ZERO, 32'hffff_ffff);
		rdchk(`MEF_IDX_MASK_ZERO, 32'h8000_0000);
		ev(10);
		chk({31'h0, irq}, 32'h1);
		bus(1'b1, `MEF_IDX_MASK_ZERO, 32'h0);
		chk({31'h0, irq}, 32'h0);
		rdchk(`MEF_IDX_CROSS_FLAGS, 32'h8000_0000);
		bus(1'b1, `MEF_IDX_CROSS_FLAGS, 32'h8000_0000);
		bus(1'b1, `MEF_IDX_ERROR_MASK, 32'h40);
		ev(8);
		chk({31'h0, irq}, 32'h1);
		bus(1'b1, `MEF_IDX_ERROR_FLAGS, 32'h40);
		chk({31'h0, irq}, 32'h0);
		ev(9);
		chk({31'h0, irq}, 32'h0);
		bus(1'b1, `MEF_IDX_ERROR_FLAGS, 32'h1);
		bus(1'b1, `MEF_IDX_SAG_MASK, 32'hffff_fff8);
		rdchk(`MEF_IDX_SAG_MASK, 32'h8);
		sagLevel <= 4'b1000;
		@(posedge clk_sys);
		sagLevel <= 4'b0000;
		@(posedge clk_sys);
		chk({31'h0, irq}, 32'h1);
		bus(1'b1, `MEF_IDX_SAG_FLAGS, 32'h8);
		chk({31'h0, irq}, 32'h0);
		bus(1'b1, `MEF_IDX_SAG_MASK, 32'h0);
	endtask : tIrq

	task automatic tRate;
		int base;
		base = takes;
		repeat (6) begin
			convDataReady <= 1'b1;
			repeat (25) @(posedge clk_sys);
			convDataReady <= 1'b0;
			repeat (25) @(posedge clk_sys);
		end
		chk(32'(takes - base), 32'h6);
		rdchk(`MEF_IDX_ERROR_FLAGS, 32'h0);
		repeat (80) @(posedge clk_sys);
		rdchk(`MEF_IDX_ERROR_FLAGS, 32'h100);
		base = takes;
		convDataReady <= 1'b1;
		repeat (10) @(posedge clk_sys);
		chk(32'(takes - base), 32'h0);
	endtask : tRate

	initial begin
		{rst_n, hsel, hwrite, convStatusValid, convCrcFail} = 5'b0;
		{convInitFail, auxFiveCrossing, convDataReady} = 3'b0;
		{haddr, hwdata, convStatus} = '0;
		{htrans, hsize, sagLevel, internalFault} = '0;
		badCount = 0;
		numChecks = 0;
		repeat (4) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		tResets();
		tSag();
		tFaults();
		tConv();
		tIrq();
		tRate();
		wrapUp();
	end

	initial begin
		repeat (6000) @(posedge clk_sys);
		badCount++;
		wrapUp();
	end
endmodule : mef_error_status_tb
